/* File: hdl/ram_trace_defines.svh */
// Constants shared by the RAM trace transmitter: packet layout, region counts and link timing.
`ifndef RAM_TRACE_DEFINES_SVH
`define RAM_TRACE_DEFINES_SVH

// --------------------------------------------------------------------------
// Packet layout
// --------------------------------------------------------------------------
`define ADDR_W 32
`define DATA_W 32
`define HDR_W 8
`define PKT_W 72
`define ENTRY_W 73
`define ENTRY_DIRECT_BIT 72
`define HDR_WRITE_BIT 7
`define HDR_DMA_BIT 6
`define HDR_PERIPH_BIT 5

// --------------------------------------------------------------------------
// Regions and link
// --------------------------------------------------------------------------
`define NUM_RAM 2
`define REGIONS_PER_RAM 2
`define DATA_PINS_DEFAULT 4
`define FIFO_DEPTH_DEFAULT 8
`define LINK_DIV_DEFAULT 1
`define LINK_MAX_MBPS 100
`define CLK_MHZ 10

// --------------------------------------------------------------------------
// Hold line timing, in system clock cycles
// --------------------------------------------------------------------------
`define HOLD_SETUP_CYCLES 3
`define RESUME_MIN_CYCLES 4
`define RESUME_MAX_CYCLES 5
`define RESUME_WAIT 1

`endif

/* File: hdl/ram_trace_pkg.sv */
// Types shared by the RAM trace transmitter.
`default_nettype none
package ram_trace_pkg;

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_HOLD = 2'b01,
        LINK_SEND = 2'b10
    } link_state_t;

    typedef enum logic {
        MASTER_CPU = 1'b0,
        MASTER_DMA = 1'b1
    } master_t;

endpackage
`default_nettype wire

/* File: hdl/trace_fifo.sv */
// Flip-flop FIFO holding captured trace entries until the link can send them.
`timescale 1ns/1ps
`default_nettype none
module trace_fifo #(
    parameter int WIDTH = 73,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Fill side.
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side.
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;

    function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    wire logic doPush = inValid && inReady;
    wire logic doPop = outValid && outReady;

    assign inReady = count_q != (AW+1)'(DEPTH);
    assign outValid = count_q != '0;
    assign outData = mem_q[rdPtr_q];

    always_ff @(posedge clk) begin
        if (doPush) begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (doPush) begin
                wrPtr_q <= nextPtr(wrPtr_q);
            end
            if (doPop) begin
                rdPtr_q <= nextPtr(rdPtr_q);
            end
            count_q <= count_q + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end

endmodule // trace_fifo
`default_nettype wire

/* File: hdl/trace_link_shifter.sv */
// Packet serializer driving the trace link clock, sync and data lines.
`timescale 1ns/1ps
`default_nettype none
`include "ram_trace_defines.svh"
module trace_link_shifter #(
    parameter int DATA_PINS = `DATA_PINS_DEFAULT,
    parameter int LINK_DIV = `LINK_DIV_DEFAULT
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Control.
    input wire logic cfgClockFree,
    input wire logic holdActive,
    // Packet source.
    input wire logic pktValid,
    input wire logic pktDirect,
    input wire logic [`PKT_W-1:0] pktData,
    output logic pktTake,
    // Link.
    output logic linkClk,
    output logic linkSync,
    output logic [DATA_PINS-1:0] linkData,
    output logic waiting
);
    localparam int DIV_W = $clog2(LINK_DIV + 1);
    localparam int CNT_W = $clog2(`PKT_W / DATA_PINS + 1);
    localparam logic [CNT_W-1:0] TRACE_BEATS = CNT_W'(`PKT_W / DATA_PINS - 1);
    localparam logic [CNT_W-1:0] DIRECT_BEATS = CNT_W'(`DATA_W / DATA_PINS - 1);
    localparam int RESUME_LO = `RESUME_MIN_CYCLES - 2;
    localparam int RESUME_HI = `RESUME_MAX_CYCLES - 2;

    ram_trace_pkg::link_state_t state_q, state_d;
    logic [DIV_W-1:0] divCnt_q;
    logic [1:0] resumeCnt_q;
    logic linkClk_q;
    logic linkSync_q;
    logic [DATA_PINS-1:0] linkData_q;
    logic [`PKT_W-1:0] shift_q;
    logic [CNT_W-1:0] beatsLeft_q;

    // ----------------------------------------------------------------------
    // Launch decision
    // ----------------------------------------------------------------------
    // One beat per link period, so the per-pin rate scales with clk; a fast
    // enough clk reaches the full link rate on every data pin.
    wire logic tick = divCnt_q == DIV_W'(LINK_DIV - 1);
    wire logic fallEdge = tick && linkClk_q;
    wire logic resumeOk = resumeCnt_q == 2'(`RESUME_WAIT);
    wire logic canLaunch = cfgClockFree ? fallEdge : !linkClk_q;
    wire logic sending = state_q == ram_trace_pkg::LINK_SEND;
    wire logic lastBeat = sending && fallEdge && (beatsLeft_q == '0);

    assign pktTake = !sending && pktValid && !holdActive && resumeOk && canLaunch;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ram_trace_pkg::LINK_IDLE, ram_trace_pkg::LINK_HOLD: begin
                if (pktTake) begin
                    state_d = ram_trace_pkg::LINK_SEND;
                end else if (pktValid) begin
                    state_d = ram_trace_pkg::LINK_HOLD;
                end else begin
                    state_d = ram_trace_pkg::LINK_IDLE;
                end
            end
            ram_trace_pkg::LINK_SEND: begin
                if (lastBeat) begin
                    state_d = ram_trace_pkg::LINK_IDLE;
                end
            end
            default: state_d = ram_trace_pkg::LINK_IDLE;
        endcase
    end

    // ----------------------------------------------------------------------
    // Clock divider, hold recovery and link clock
    // ----------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= ram_trace_pkg::LINK_IDLE;
            divCnt_q <= '0;
            resumeCnt_q <= 2'(`RESUME_WAIT);
        end else begin
            state_q <= state_d;
            divCnt_q <= tick ? '0 : divCnt_q + 1'b1;
            if (holdActive) begin
                resumeCnt_q <= '0;
            end else if (!resumeOk) begin
                resumeCnt_q <= resumeCnt_q + 1'b1;
            end
        end
    end

    // A stopped clock parks low so that a packet can start at once.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            linkClk_q <= 1'b0;
        end else if (pktTake) begin
            linkClk_q <= 1'b0;
        end else if (sending || cfgClockFree) begin
            linkClk_q <= tick ? !linkClk_q : linkClk_q;
        end else begin
            linkClk_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------------
    // Shifter: data changes on falling link edges, sampled on rising ones
    // ----------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            linkSync_q <= 1'b0;
            linkData_q <= '0;
            shift_q <= '0;
            beatsLeft_q <= '0;
        end else if (pktTake) begin
            linkSync_q <= 1'b1;
            linkData_q <= pktData[`PKT_W-1 -: DATA_PINS];
            shift_q <= pktData << DATA_PINS;
            beatsLeft_q <= pktDirect ? DIRECT_BEATS : TRACE_BEATS;
        end else if (sending && fallEdge) begin
            linkSync_q <= 1'b0;
            if (lastBeat) begin
                linkData_q <= '0;
            end else begin
                linkData_q <= shift_q[`PKT_W-1 -: DATA_PINS];
                shift_q <= shift_q << DATA_PINS;
                beatsLeft_q <= beatsLeft_q - 1'b1;
            end
        end
    end

    assign linkClk = linkClk_q;
    assign linkSync = linkSync_q;
    assign linkData = linkData_q;
    assign waiting = state_q == ram_trace_pkg::LINK_HOLD;

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    a_hold_delays_sync: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(linkSync_q) |-> !$past(holdActive))
        else $error("Packet started while hold was active.");

    a_resume_window: assert property (@(posedge clk) disable iff (!rst_b)
        ($fell(holdActive) && state_q == ram_trace_pkg::LINK_HOLD && pktValid)
            |-> ##[RESUME_LO:RESUME_HI] $rose(linkSync_q))
        else $error("Held packet did not resume in its window.");

    a_sync_one_beat: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(linkSync_q) |-> linkSync_q[*2] ##1 !linkSync_q)
        else $error("Sync did not mark exactly the first beat.");

    a_clock_parked: assert property (@(posedge clk) disable iff (!rst_b)
        (!cfgClockFree && state_q != ram_trace_pkg::LINK_SEND) |=> !linkClk_q)
        else $error("Stopped link clock toggled outside a packet.");

endmodule // trace_link_shifter
`default_nettype wire

/* File: hdl/ram_trace_transmitter.sv */
// RAM trace transmitter: captures bus accesses or direct words and sends them over the trace link.
`timescale 1ns/1ps
`default_nettype none
`include "ram_trace_defines.svh"
module ram_trace_transmitter #(
    parameter int DATA_PINS = `DATA_PINS_DEFAULT,
    parameter int FIFO_DEPTH = `FIFO_DEPTH_DEFAULT,
    parameter int LINK_DIV = `LINK_DIV_DEFAULT,
    parameter int NUM_RAM = `NUM_RAM,
    parameter int RAM_SEL_W = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Configuration.
    input wire logic cfgEnable,
    input wire logic cfgDirectMode,
    input wire logic cfgTraceWrites,
    input wire logic cfgTraceReads,
    input wire logic cfgTraceCpu,
    input wire logic cfgTraceDma,
    input wire logic cfgTracePeriph,
    input wire logic cfgClockFree,
    input wire logic [NUM_RAM*`REGIONS_PER_RAM-1:0] cfgRegionEn,
    input wire logic [NUM_RAM*`REGIONS_PER_RAM*`ADDR_W-1:0] cfgRegionLo,
    input wire logic [NUM_RAM*`REGIONS_PER_RAM*`ADDR_W-1:0] cfgRegionHi,
    input wire logic [DATA_PINS+1:0] cfgPinTrace,
    // Observed bus accesses.
    input wire logic busValid,
    input wire logic busWrite,
    input wire logic busMaster,
    input wire logic busPeriph,
    input wire logic [RAM_SEL_W-1:0] busRamSel,
    input wire logic [`ADDR_W-1:0] busAddr,
    input wire logic [`DATA_W-1:0] busData,
    // Direct data words.
    input wire logic directValid,
    output logic directReady,
    input wire logic [`DATA_W-1:0] directData,
    // Status.
    output logic overflowPulse,
    output logic overflowFlag,
    input wire logic overflowClear,
    output logic packetWaiting,
    // Trace link clock pin.
    output logic traceLinkClockOut,
    output logic traceLinkClockOe,
    input wire logic traceLinkClockIn,
    // Trace packet sync pin.
    output logic tracePacketSyncOut,
    output logic tracePacketSyncOe,
    input wire logic tracePacketSyncIn,
    // Trace link data pins.
    output logic [DATA_PINS-1:0] traceLinkDataOut,
    output logic [DATA_PINS-1:0] traceLinkDataOe,
    input wire logic [DATA_PINS-1:0] traceLinkDataIn,
    // Hold request from the receiver, high means hold.
    input wire logic traceHoldRequest_n,
    // General-purpose use of unused pins.
    input wire logic [DATA_PINS+1:0] gpioOut,
    input wire logic [DATA_PINS+1:0] gpioOe,
    output logic [DATA_PINS+1:0] gpioIn
);
    localparam int NPINS = DATA_PINS + 2;
    localparam int NREG = NUM_RAM * `REGIONS_PER_RAM;

    // ----------------------------------------------------------------------
    // Region decode
    // ----------------------------------------------------------------------
    function automatic logic inWindow(input logic [`ADDR_W-1:0] a,
                                      input logic [`ADDR_W-1:0] lo,
                                      input logic [`ADDR_W-1:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    logic [NREG-1:0] regionHit;

    for (genvar i = 0; i < NREG; i++) begin : g_region
        assign regionHit[i] = cfgRegionEn[i]
            && (busRamSel == RAM_SEL_W'(i / `REGIONS_PER_RAM))
            && inWindow(busAddr, cfgRegionLo[i*`ADDR_W +: `ADDR_W], cfgRegionHi[i*`ADDR_W +: `ADDR_W]);
    end

    // ----------------------------------------------------------------------
    // Capture qualification
    // ----------------------------------------------------------------------
    // The bus is only observed; nothing here can stall it, so a busy link
    // costs entries (counted as overflow), never program time.
    wire logic ramHit = !busPeriph && (|regionHit);
    wire logic periphHit = busPeriph && cfgTracePeriph;
    wire logic masterOk = (busMaster == ram_trace_pkg::MASTER_DMA) ? cfgTraceDma : cfgTraceCpu;
    wire logic dirOk = busWrite ? cfgTraceWrites : cfgTraceReads;
    wire logic traceHit = cfgEnable && busValid && masterOk && dirOk && (ramHit || periphHit);

    wire logic captureWant = traceHit && !cfgDirectMode;
    wire logic readWant = traceHit && cfgDirectMode && !busWrite;
    wire logic directWant = cfgEnable && cfgDirectMode && directValid;
    wire logic traceWant = captureWant || readWant;

    // ----------------------------------------------------------------------
    // FIFO entry build
    // ----------------------------------------------------------------------
    wire logic [`HDR_W-1:0] header = {busWrite, busMaster, busPeriph, 1'b0, 4'(busRamSel)};
    wire logic [`DATA_W-1:0] bareWord = directWant ? directData : busData;
    wire logic [`ENTRY_W-1:0] traceEntry = {1'b0, header, busAddr, busData};
    wire logic [`ENTRY_W-1:0] bareEntry = {1'b1, bareWord, {(`PKT_W-`DATA_W){1'b0}}};

    logic fifoInReady;
    logic fifoOutValid;
    logic [`ENTRY_W-1:0] fifoOutData;
    logic pktTake;

    wire logic pushValid = captureWant || directWant || readWant;
    wire logic [`ENTRY_W-1:0] pushData = cfgDirectMode ? bareEntry : traceEntry;

    // A traced read colliding with a direct word loses its slot.
    wire logic overflowEvent = (traceWant && !fifoInReady) || (readWant && directWant);

    assign directReady = fifoInReady && cfgEnable && cfgDirectMode;

    trace_fifo #(
        .WIDTH(`ENTRY_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .inValid(pushValid),
        .inReady(fifoInReady),
        .inData(pushData),
        .outValid(fifoOutValid),
        .outReady(pktTake),
        .outData(fifoOutData)
    );

    // ----------------------------------------------------------------------
    // Overflow flag
    // ----------------------------------------------------------------------
    logic overflowFlag_q;
    logic overflowPulse_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            overflowFlag_q <= 1'b0;
            overflowPulse_q <= 1'b0;
        end else begin
            overflowPulse_q <= overflowEvent;
            if (overflowEvent) begin
                overflowFlag_q <= 1'b1;
            end else if (overflowClear) begin
                overflowFlag_q <= 1'b0;
            end
        end
    end

    assign overflowFlag = overflowFlag_q;
    assign overflowPulse = overflowPulse_q;

    // ----------------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------------
    // Two hold flops, one recovery cycle and the launch give the four-cycle
    // resume in stop mode; free-running mode may wait one more cycle for a
    // falling link edge, which is why the window is four to five cycles.
    logic holdSync1_q;
    logic holdSync2_q;
    logic [NPINS-1:0] pinSync1_q;
    logic [NPINS-1:0] pinSync2_q;
    wire logic [NPINS-1:0] pinIn = {traceLinkDataIn, tracePacketSyncIn, traceLinkClockIn};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            holdSync1_q <= 1'b0;
            holdSync2_q <= 1'b0;
            pinSync1_q <= '0;
            pinSync2_q <= '0;
        end else begin
            holdSync1_q <= traceHoldRequest_n;
            holdSync2_q <= holdSync1_q;
            pinSync1_q <= pinIn;
            pinSync2_q <= pinSync1_q;
        end
    end

    assign gpioIn = pinSync2_q;

    // ----------------------------------------------------------------------
    // Link serializer
    // ----------------------------------------------------------------------
    logic linkClk;
    logic linkSync;
    logic [DATA_PINS-1:0] linkData;

    trace_link_shifter #(
        .DATA_PINS(DATA_PINS),
        .LINK_DIV(LINK_DIV)
    ) u_shifter (
        .clk(clk),
        .rst_b(rst_b),
        .cfgClockFree(cfgClockFree),
        .holdActive(holdSync2_q),
        .pktValid(fifoOutValid),
        .pktDirect(fifoOutData[`ENTRY_DIRECT_BIT]),
        .pktData(fifoOutData[`PKT_W-1:0]),
        .pktTake(pktTake),
        .linkClk(linkClk),
        .linkSync(linkSync),
        .linkData(linkData),
        .waiting(packetWaiting)
    );

    // ----------------------------------------------------------------------
    // Pin multiplexing
    // ----------------------------------------------------------------------
    // Trace pins always drive; a general-purpose pin drives only when its
    // enable is set, so an unused pin stays an input after reset.
    wire logic [NPINS-1:0] traceVal = {linkData, linkSync, linkClk};
    wire logic [NPINS-1:0] pinOut = (cfgPinTrace & traceVal) | (~cfgPinTrace & gpioOut);
    wire logic [NPINS-1:0] pinOe = cfgPinTrace | (~cfgPinTrace & gpioOe);

    assign traceLinkClockOut = pinOut[0];
    assign traceLinkClockOe = pinOe[0];
    assign tracePacketSyncOut = pinOut[1];
    assign tracePacketSyncOe = pinOe[1];
    assign traceLinkDataOut = pinOut[NPINS-1:2];
    assign traceLinkDataOe = pinOe[NPINS-1:2];

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_overflow_sticky: assert property (
        overflowEvent |=> overflowFlag_q && overflowPulse_q)
        else $error("Overflow was not reported.");

    a_region_filter: assert property (
        (captureWant && !busPeriph) |-> (|(regionHit & cfgRegionEn)))
        else $error("RAM access outside enabled windows was traced.");

    a_master_filter: assert property (
        pushValid && !cfgDirectMode |-> (busMaster ? cfgTraceDma : cfgTraceCpu))
        else $error("Access from a disabled master was traced.");

    a_header_master: assert property (
        (pushValid && fifoInReady && !cfgDirectMode)
            |-> pushData[`DATA_W+`ADDR_W+`HDR_DMA_BIT] == busMaster && !pushData[`ENTRY_DIRECT_BIT])
        else $error("Header master field does not match the access.");

    a_direct_bare: assert property (
        (pushValid && cfgDirectMode)
            |-> pushData[`ENTRY_DIRECT_BIT] && pushData[`PKT_W-`DATA_W-1:0] == '0)
        else $error("Direct entry carries header or address bits.");

    a_no_stall_write: assert property (
        (pushValid && !fifoInReady) |-> ##1 !$stable(overflowPulse_q) || overflowPulse_q || directWant)
        else $error("Entry refused by a full FIFO went unreported.");

    a_pin_release: assert property (
        ((~cfgPinTrace) & ({traceLinkDataOut, tracePacketSyncOut, traceLinkClockOut} ^ gpioOut)) == '0)
        else $error("A general-purpose pin ignored its drive value.");

    a_trace_driven: assert property (
        (cfgPinTrace & ~{traceLinkDataOe, tracePacketSyncOe, traceLinkClockOe}) == '0)
        else $error("A trace pin was left undriven.");

    a_clear_works: assert property (
        (overflowClear && !overflowEvent) |=> !overflowFlag_q)
        else $error("Overflow flag ignored its clear.");

    a_pulse_cause: assert property (
        overflowPulse_q |-> $past(overflowEvent))
        else $error("Overflow pulse without a lost entry.");

    a_hold_waits: assert property (
        holdSync2_q |=> !$rose(linkSync))
        else $error("Hold did not block the next sync.");

    a_wait_queued: assert property (
        packetWaiting |-> fifoOutValid)
        else $error("Waiting flag raised with no packet queued.");

endmodule // ram_trace_transmitter
`default_nettype wire

/* File: tb/trace_capture_model.sv */
// Receiver model that samples the trace link and drives the hold line.
`timescale 1ns/1ps
`default_nettype none
module trace_capture_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Link.
    input wire logic linkClk,
    input wire logic sync,
    input wire logic [3:0] data,
    input wire logic holdCmd,
    output logic traceHoldRequest_n
);
    logic clkPrev_q;
    logic [71:0] cap;
    int beats;
    int nSync;
    assign traceHoldRequest_n = holdCmd;
    // The link clock comes from flops, so it is sampled like any slow input.
    always @(posedge clk) begin
        clkPrev_q <= linkClk;
        if (!rst_b) begin
            beats <= 0;
            nSync <= 0;
        end else if (linkClk && !clkPrev_q) begin
            beats <= sync ? 1 : beats + 1;
            cap <= sync ? {68'h0, data} : {cap[67:0], data};
            nSync <= nSync + int'(sync);
        end
    end
endmodule // trace_capture_model
`default_nettype wire

/* File: tb/test_ram_trace_transmitter.sv */
// Self-checking bench for the RAM trace transmitter.
`timescale 1ns/1ps
`default_nettype none
module test_ram_trace_transmitter;
    logic clk = 1'b0, rst_b = 1'b0, dirMode = 1'b0, cpuEn = 1'b1, freeClk = 1'b0, ovClr = 1'b0, holdCmd = 1'b0;
    logic bV = 1'b0, bW = 1'b0, bM = 1'b0, bP = 1'b0, bR = 1'b0, dV = 1'b0, dRdy, ovFlag, waitPkt, lClk, lSync;
    logic [31:0] bA = 32'h0, bD = 32'h0, dD = 32'h0, seed = 32'h8674, rv, ra;
    logic [3:0] lD, dOut, dOe;
    logic cOut, cOe, sOut, sOe, hold_n;
    logic rdEn = 1'b1, dmaEn = 1'b1, perEn = 1'b1, ovPulse;
    logic [5:0] pinTr = 6'h3f, gOut = 6'h0, gOe = 6'h0, gIn;
    logic [71:0] first;
    int fails = 0, nCompared = 0, nPulse = 0, s, k, i;
    assign lClk = cOut & cOe;
    assign lSync = sOut & sOe;
    assign lD = dOut & dOe;
    always #50 clk = ~clk;
    always @(posedge clk) nPulse <= nPulse + int'(ovPulse === 1'b1);
    ram_trace_transmitter dut (.clk(clk), .rst_b(rst_b), .cfgEnable(1'b1), .cfgDirectMode(dirMode),
        .cfgTraceWrites(1'b1), .cfgTraceReads(rdEn), .cfgTraceCpu(cpuEn), .cfgTraceDma(dmaEn),
        .cfgTracePeriph(perEn), .cfgClockFree(freeClk), .cfgRegionEn(4'h5),
        .cfgRegionLo({64'h0, 32'h08000000, 32'h0, 32'h00001000}),
        .cfgRegionHi({64'h0, 32'h080000ff, 32'h0, 32'h00001fff}), .cfgPinTrace(pinTr),
        .busValid(bV), .busWrite(bW), .busMaster(bM), .busPeriph(bP), .busRamSel(bR), .busAddr(bA),
        .busData(bD), .directValid(dV), .directReady(dRdy), .directData(dD), .overflowPulse(ovPulse),
        .overflowFlag(ovFlag), .overflowClear(ovClr), .packetWaiting(waitPkt), .traceLinkClockOut(cOut),
        .traceLinkClockOe(cOe), .traceLinkClockIn(lClk), .tracePacketSyncOut(sOut), .tracePacketSyncOe(sOe),
        .tracePacketSyncIn(lSync), .traceLinkDataOut(dOut), .traceLinkDataOe(dOe), .traceLinkDataIn(lD),
        .traceHoldRequest_n(hold_n), .gpioOut(gOut), .gpioOe(gOe), .gpioIn(gIn));
    trace_capture_model m (.clk(clk), .rst_b(rst_b), .linkClk(lClk), .sync(lSync), .data(lD),
        .holdCmd(holdCmd), .traceHoldRequest_n(hold_n));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [71:0] pkt(logic w, logic d, logic p, logic r, logic [31:0] a, logic [31:0] v);
        return {w, d, p, 4'h0, r, a, v};
    endfunction
    task automatic chk(string n, logic [71:0] e, logic [71:0] g);
        nCompared++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask
    task automatic send(logic w, logic d, logic p, logic r, logic [31:0] a, logic [31:0] v);
        @(posedge clk);
        bV <= 1'b1;
        bW <= w;
        bM <= d;
        bP <= p;
        bR <= r;
        bA <= a;
        bD <= v;
        @(posedge clk);
        bV <= 1'b0;
    endtask
    task automatic expPkt(logic [71:0] e, int nb, int s0);
        k = 0;
        while ((m.nSync == s0 || m.beats != nb) && k < 300) begin
            @(posedge clk);
            k++;
        end
        chk("packet", e, m.cap);
    endtask
    task automatic testDone();
        $display("compared %0d mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #(100 * 20000);
        fails++;
        testDone();
    end
    // ----------------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        for (i = 0; i < 3; i++) begin
            rv = rnd();
            ra = i == 0 ? 32'h1000 | (rnd() & 32'hfff) : i == 1 ? 32'h080000ff : rnd();
            s = m.nSync;
            send(i != 1, i == 1, i == 2, i == 1, ra, rv);
            expPkt(pkt(i != 1, i == 1, i == 2, i == 1, ra, rv), 18, s);
        end
        for (i = 0; i < 5; i++) begin
            cpuEn <= i != 1;
            dmaEn <= i != 2;
            perEn <= i != 3;
            rdEn <= i != 4;
            s = m.nSync;
            send(i != 4, i == 2, i == 3, 1'b0, i == 0 ? 32'h2000 : 32'h1004, rnd());
            repeat (60) @(posedge clk);
            chk("filtered", 72'(s), 72'(m.nSync));
        end
        cpuEn <= 1'b1;
        dmaEn <= 1'b1;
        perEn <= 1'b1;
        rdEn <= 1'b1;
        holdCmd <= 1'b1;
        repeat (6) @(posedge clk);
        s = m.nSync;
        first = pkt(1'b1, 1'b0, 1'b0, 1'b0, 32'h1ffc, rnd());
        send(1'b1, 1'b0, 1'b0, 1'b0, 32'h1ffc, first[31:0]);
        repeat (30) @(posedge clk);
        chk("held", 72'(s), 72'(m.nSync));
        chk("waiting", 72'h1, 72'(waitPkt));
        holdCmd <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while (sOut !== 1'b1 && k < 20);
        chk("resume", 72'h1, 72'(k inside {[4:5]}));
        expPkt(first, 18, s);
        freeClk <= 1'b1;
        holdCmd <= 1'b1;
        repeat (6) @(posedge clk);
        s = m.nSync;
        for (i = 0; i < 12; i++) send(1'b1, 1'b1, 1'b0, 1'b1, 32'h08000000 + i, 32'(i));
        chk("overflow", 72'h1, 72'(ovFlag));
        ovClr <= 1'b1;
        @(posedge clk);
        ovClr <= 1'b0;
        holdCmd <= 1'b0;
        repeat (2) @(posedge clk);
        chk("cleared", 72'h0, 72'(ovFlag));
        chk("pulses", 72'd4, 72'(nPulse));
        expPkt(pkt(1'b1, 1'b1, 1'b0, 1'b1, 32'h08000000, 32'h0), 18, s);
        repeat (600) @(posedge clk);
        dirMode <= 1'b1;
        for (i = 0; i < 3; i++) begin
            s = m.nSync;
            rv = rnd();
            if (i == 2) send(1'b0, 1'b0, 1'b0, 1'b0, 32'h1100, rv);
            else begin
                @(posedge clk);
                dV <= 1'b1;
                dD <= rv;
                k = 0;
                do @(posedge clk); while (dRdy !== 1'b1 && ++k < 50);
                dV <= 1'b0;
            end
            expPkt({40'h0, rv}, 8, s);
        end
        pinTr <= 6'h03;
        gOe <= 6'h3c;
        gOut <= 6'(rnd());
        repeat (3) @(posedge clk);
        chk("gpio", 72'({gOut[5:2], 4'hf}), 72'({dOut, dOe}));
        chk("gpioIn", 72'(gOut[5:2]), 72'(gIn[5:2]));
        testDone();
    end
endmodule // test_ram_trace_transmitter
`default_nettype wire
